// file: common/pos_defines.svh
// constants for the port overcurrent sense block
// Notes on behaviour
// - while a port is powered its shared pin is sampled continuously.
// - low held for the configured minimum width flags an overcurrent.
// - two low groups inside the rolling window flag an overcurrent.
// - after power on the pin is ignored for the lockout time.
// - minimum width in bits 3:0, 0 to 15 ms, reset 5 ms.
// - window length is eight bits in 1 ms units.
// - window register resets to 20 ms, 8'h14.
// - lockout is eight bits in 1 ms units; events inside it are dropped.
// - lockout register resets to 10 ms, 8'h0a.
// - power off drives the pin low and turns the pull-up off.
// - power on releases the driver and turns the pull-up on.
// - a low on the powered pin counts as an overcurrent sign.
// - in ganged mode only port 0's pin is sensed, and an overcurrent on it flags every port.
`ifndef POS_DEFINES_SVH
`define POS_DEFINES_SVH
`define POS_NPORT 6
`define POS_CLK_HZ 10000000
`define POS_TICK_MS 1
`define POS_TICK_CYCLES (`POS_CLK_HZ / 1000 * `POS_TICK_MS)
`define POS_IDX_LOCKOUT 16'h30e1
`define POS_IDX_MINW 16'h30ea
`define POS_IDX_WINDOW 16'h30eb
`define POS_IDX_CTRL 16'h3100
`define POS_IDX_STATUS 16'h3101
`define POS_IDX_MASK 16'h3102
`define POS_IDX_STATE 16'h3103
`define POS_ADDR_LOCKOUT 16'(`POS_IDX_LOCKOUT * 4)
`define POS_ADDR_MINW 16'(`POS_IDX_MINW * 4)
`define POS_ADDR_WINDOW 16'(`POS_IDX_WINDOW * 4)
`define POS_ADDR_CTRL 16'(`POS_IDX_CTRL * 4)
`define POS_ADDR_STATUS 16'(`POS_IDX_STATUS * 4)
`define POS_ADDR_MASK 16'(`POS_IDX_MASK * 4)
`define POS_ADDR_STATE 16'(`POS_IDX_STATE * 4)
`define POS_LOCKOUT_RST 8'h0a
`define POS_MINW_RST 4'h5
`define POS_WINDOW_RST 8'h14
`define POS_CTRL_GANG_BIT 8
`define POS_RESP_OKAY 2'b00
`define POS_RESP_SLVERR 2'b10
`endif

// file: common/pos_pkg.sv
// types for the port overcurrent sense block
package pos_pkg;
    typedef struct packed {
        logic [3:0] min_width;
        logic [7:0] window;
        logic [7:0] lockout;
    } pos_cfg_s;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_LOCK = 2'b01,
        ST_SENSE = 2'b10
    } pos_state_e;
endpackage : pos_pkg

// file: verilog/pos_port.sv
// per port lockout, single and double pulse overcurrent detector
`timescale 1ns/1ps
`include "pos_defines.svh"
module pos_port (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // timebase and settings
    input wire logic tick,
    input wire pos_pkg::pos_cfg_s cfg,
    // port side
    input wire logic pwr_en,
    input wire logic low,
    output logic oc_det
);
    pos_pkg::pos_state_e st_q, st_d;
    logic [7:0] lock_q, lock_d;
    logic [3:0] low_ms_q, low_ms_d;
    logic [7:0] win_q, win_d;
    logic prev_q, prev_d;
    logic det_q, det_d;

    always_comb begin
        st_d = st_q;
        lock_d = lock_q;
        low_ms_d = 4'h0;
        win_d = 8'h00;
        prev_d = low;
        det_d = 1'b0;
        unique case (st_q)
            pos_pkg::ST_OFF: begin
                if (pwr_en) begin
                    st_d = pos_pkg::ST_LOCK;
                    lock_d = cfg.lockout;
                end
            end
            pos_pkg::ST_LOCK: begin
                if (!pwr_en) begin
                    st_d = pos_pkg::ST_OFF;
                end else if (tick) begin
                    if (lock_q <= 8'h01) begin
                        st_d = pos_pkg::ST_SENSE;
                    end
                    lock_d = (lock_q == 8'h00) ? 8'h00 : lock_q - 8'h01;
                end
            end
            pos_pkg::ST_SENSE: begin
                if (!pwr_en) begin
                    st_d = pos_pkg::ST_OFF;
                end else begin
                    low_ms_d = low_ms_q;
                    win_d = win_q;
                    if (!low) begin
                        low_ms_d = 4'h0;
                    end else if (tick && low_ms_q != 4'hf) begin
                        low_ms_d = low_ms_q + 4'h1;
                    end
                    if (win_q != 8'h00 && tick) begin
                        win_d = win_q - 8'h01;
                    end
                    if (!low && prev_q) begin
                        win_d = cfg.window;
                    end
                    if (low && low_ms_q >= cfg.min_width) begin
                        det_d = 1'b1;
                    end
                    if (low && !prev_q && win_q != 8'h00) begin
                        det_d = 1'b1;
                    end
                    if (det_d) begin
                        low_ms_d = 4'h0;
                        win_d = 8'h00;
                    end
                end
            end
            default: st_d = pos_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= pos_pkg::ST_OFF;
            lock_q <= 8'h00;
            low_ms_q <= 4'h0;
            win_q <= 8'h00;
            prev_q <= 1'b0;
            det_q <= 1'b0;
        end else begin
            st_q <= st_d;
            lock_q <= lock_d;
            low_ms_q <= low_ms_d;
            win_q <= win_d;
            prev_q <= prev_d;
            det_q <= det_d;
        end
    end

    assign oc_det = det_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_second_group;
        st_q == pos_pkg::ST_SENSE && pwr_en && win_q != 8'h00 && low && !prev_q;
    endsequence
    a_power_on_lock: assert property (
        st_q == pos_pkg::ST_OFF && pwr_en |=> st_q == pos_pkg::ST_LOCK
            && lock_q == $past(cfg.lockout)) else $error("no lockout");
    a_lock_drops_events: assert property (
        st_q != pos_pkg::ST_SENSE |=> !det_q) else $error("event in lock");
    a_single_width: assert property (
        st_q == pos_pkg::ST_SENSE && pwr_en && low && low_ms_q >= cfg.min_width
            |=> det_q) else $error("long low missed");
    a_double_pulse: assert property (
        s_second_group |=> det_q) else $error("double pulse missed");
endmodule : pos_port

// file: verilog/pos_top.sv
// port power control and overcurrent sense with axi4-lite registers
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pos_defines.svh"
module pos_top #(
    parameter int TICK_CYCLES = `POS_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // axi4-lite write address and data
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // port power sense pins
    input wire logic [`POS_NPORT-1:0] port_power_sense_pin_i,
    output logic [`POS_NPORT-1:0] port_power_sense_pin_o,
    output logic [`POS_NPORT-1:0] port_power_sense_pin_oe,
    output logic [`POS_NPORT-1:0] pullup_en,
    // interrupt
    output logic irq
);
    localparam int N = `POS_NPORT;

    // millisecond timebase
    logic [15:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;

    always_comb begin
        tick_d = (tick_cnt_q == 16'h0000);
        tick_cnt_d = tick_d ? 16'(TICK_CYCLES - 1) : tick_cnt_q - 16'h0001;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
        end
    end

    // configuration, control and status registers
    pos_pkg::pos_cfg_s cfg_q, cfg_d;
    logic [N-1:0] en_q, en_d;
    logic gang_q, gang_d;
    logic [N-1:0] status_q, status_d;
    logic [N-1:0] mask_q, mask_d;
    logic irq_q, irq_d;
    logic [N-1:0] irq_src;
    logic [N-1:0] det;
    logic [N-1:0] set;
    logic [N-1:0] pwr_eff;

    // pin drive and input synchroniser
    logic [N-1:0] pwr_q;
    logic [N-1:0] pin_o_q, pin_oe_q, pullup_q;
    logic [N-1:0] pin_oe_d, pullup_d;
    logic [N-1:0] sync1_q, sync2_q, sync3_q, level_q, level_d;
    logic [N-1:0] low;

    always_comb begin
        pwr_eff = gang_q ? {N{en_q[0]}} : en_q;
        pin_oe_d = ~pwr_eff;
        pullup_d = pwr_eff;
        level_d = level_q;
        for (int i = 0; i < N; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
                level_d[i] = sync3_q[i];
            end
        end
        for (int i = 0; i < N; i++) begin
            low[i] = gang_q ? !level_q[0] : !level_q[i];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_q <= '0;
            pin_o_q <= '0;
            pin_oe_q <= '1;
            pullup_q <= '0;
            sync1_q <= '1;
            sync2_q <= '1;
            sync3_q <= '1;
            level_q <= '1;
        end else begin
            pwr_q <= pwr_eff;
            pin_o_q <= '0;
            pin_oe_q <= pin_oe_d;
            pullup_q <= pullup_d;
            sync1_q <= port_power_sense_pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            level_q <= level_d;
        end
    end

    // one detector per port
    for (genvar g = 0; g < N; g++) begin : g_port
        pos_port u_port (
            .clk(clk),
            .srst(srst),
            .tick(tick_q),
            .cfg(cfg_q),
            .pwr_en(pwr_q[g] & pullup_q[g]),
            .low(low[g]),
            .oc_det(det[g])
        );
    end

    // axi4-lite slave state
    logic awready_q, awready_d, wready_q, wready_d;
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [15:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic aw_take, w_take, wr_do, ar_take;
    logic [N-1:0] clr;

    always_comb begin
        aw_take = s_axi_awvalid && awready_q;
        w_take = s_axi_wvalid && wready_q;
        ar_take = s_axi_arvalid && arready_q;
        wr_do = aw_full_q && w_full_q && !bvalid_q;
        aw_addr_d = aw_take ? s_axi_awaddr : aw_addr_q;
        w_data_d = w_take ? s_axi_wdata : w_data_q;
        w_strb_d = w_take ? s_axi_wstrb : w_strb_q;
        aw_full_d = (aw_full_q && !wr_do) || aw_take;
        w_full_d = (w_full_q && !wr_do) || w_take;
        awready_d = !aw_full_d;
        wready_d = !w_full_d;
        bvalid_d = (bvalid_q && !s_axi_bready) || wr_do;
        bresp_d = bresp_q;
        rvalid_d = (rvalid_q && !s_axi_rready) || ar_take;
        arready_d = !rvalid_d;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        cfg_d = cfg_q;
        en_d = en_q;
        gang_d = gang_q;
        mask_d = mask_q;
        clr = '0;
        if (wr_do) begin
            bresp_d = `POS_RESP_OKAY;
            unique case (aw_addr_q)
                `POS_ADDR_LOCKOUT: begin
                    if (w_strb_q[0]) begin
                        cfg_d.lockout = w_data_q[7:0];
                    end
                end
                `POS_ADDR_MINW: begin
                    if (w_strb_q[0]) begin
                        cfg_d.min_width = w_data_q[3:0];
                    end
                end
                `POS_ADDR_WINDOW: begin
                    if (w_strb_q[0]) begin
                        cfg_d.window = w_data_q[7:0];
                    end
                end
                `POS_ADDR_CTRL: begin
                    if (w_strb_q[0]) begin
                        en_d = w_data_q[N-1:0];
                    end
                    if (w_strb_q[1]) begin
                        gang_d = w_data_q[`POS_CTRL_GANG_BIT];
                    end
                end
                `POS_ADDR_MASK: begin
                    if (w_strb_q[0]) begin
                        mask_d = w_data_q[N-1:0];
                    end
                end
                `POS_ADDR_STATUS, `POS_ADDR_STATE: begin
                end
                default: bresp_d = `POS_RESP_SLVERR;
            endcase
        end
        if (ar_take) begin
            rresp_d = `POS_RESP_OKAY;
            unique case (s_axi_araddr)
                `POS_ADDR_LOCKOUT: rdata_d = {24'h000000, cfg_q.lockout};
                `POS_ADDR_MINW: rdata_d = {28'h0000000, cfg_q.min_width};
                `POS_ADDR_WINDOW: rdata_d = {24'h000000, cfg_q.window};
                `POS_ADDR_CTRL: rdata_d = {23'h000000, gang_q, 2'b00, en_q};
                `POS_ADDR_STATUS: begin
                    rdata_d = {26'h0000000, status_q};
                    clr = status_q;
                end
                `POS_ADDR_MASK: rdata_d = {26'h0000000, mask_q};
                `POS_ADDR_STATE: rdata_d = {18'h00000, pwr_q, 2'b00, level_q};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = `POS_RESP_SLVERR;
                end
            endcase
        end
        set = gang_q ? {N{|det}} : det;
        status_d = (status_q & ~clr) | set;
        irq_src = status_q & mask_q;
        irq_d = |irq_src;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 16'h0000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `POS_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `POS_RESP_OKAY;
            cfg_q.lockout <= `POS_LOCKOUT_RST;
            cfg_q.min_width <= `POS_MINW_RST;
            cfg_q.window <= `POS_WINDOW_RST;
            en_q <= '0;
            gang_q <= 1'b0;
            status_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            cfg_q <= cfg_d;
            en_q <= en_d;
            gang_q <= gang_d;
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign port_power_sense_pin_o = pin_o_q;
    assign port_power_sense_pin_oe = pin_oe_q;
    assign pullup_en = pullup_q;
    assign irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_pin_off_drive: assert property (
        ##1 pin_oe_q == ~$past(pwr_eff) && (pin_o_q == '0))
        else $error("pin drive wrong");
    a_pullup_follow: assert property (
        ##1 pullup_q == $past(pwr_eff)) else $error("pull-up wrong");
    a_gang_all_flag: assert property (
        gang_q && (|det) |=> (&status_q)) else $error("gang not spread");
    a_irq_level: assert property (
        ##1 irq_q == (|$past(irq_src))) else $error("irq level wrong");
    a_tick_period: assert property (
        tick_q |-> $past(tick_cnt_q) == 16'h0000) else $error("tick early");
    a_reset_values: assert property (
        $fell(srst) |-> cfg_q.lockout == `POS_LOCKOUT_RST
            && cfg_q.window == `POS_WINDOW_RST
            && cfg_q.min_width == `POS_MINW_RST)
        else $error("bad reset value");
endmodule : pos_top

// file: tb/pos_switch_model.sv
// power switch model resolving the shared open-drain overcurrent line
`timescale 1ns/1ps
`include "pos_defines.svh"
module pos_switch_model (
    // clock
    input wire logic clk,
    // hub side of the line
    input wire logic [`POS_NPORT-1:0] pin_o,
    input wire logic [`POS_NPORT-1:0] pin_oe,
    input wire logic [`POS_NPORT-1:0] pullup_en,
    // switch fault flags from the bench
    input wire logic [`POS_NPORT-1:0] oc_fault,
    // resolved line level
    output logic [`POS_NPORT-1:0] pin
);
    logic [`POS_NPORT-1:0] float_q = '0;
    logic [`POS_NPORT-1:0] float_d;
    // undriven line shows a changing level, not the last one
    always_comb begin
        float_d = ~float_q;
        for (int i = 0; i < `POS_NPORT; i++) begin
            if (pin_oe[i]) begin
                pin[i] = pin_o[i];
            end else if (oc_fault[i]) begin
                pin[i] = 1'b0;
            end else if (pullup_en[i]) begin
                // fuse side: line is good as soon as the pull-up is on
                pin[i] = 1'b1;
            end else begin
                pin[i] = float_q[i];
            end
        end
    end
    always_ff @(posedge clk) begin
        float_q <= float_d;
    end
endmodule : pos_switch_model

// file: tb/port_overcurrent_sense_tb.sv
// self-checking bench for the port overcurrent sense block
`timescale 1ns/1ps
`include "pos_defines.svh"
module port_overcurrent_sense_tb;
    typedef struct {
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } pos_row_s;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, data;
    logic [`POS_NPORT-1:0] pin, pin_o, pin_oe, pullup_en;
    logic [`POS_NPORT-1:0] oc_fault = '0;
    int errors = 0;
    int checks = 0;
    pos_row_s rows [11] = '{
        '{`POS_ADDR_LOCKOUT, 32'h103, 32'h03, `POS_RESP_OKAY},
        '{`POS_ADDR_WINDOW, 32'h04, 32'h04, `POS_RESP_OKAY},
        '{`POS_ADDR_MINW, 32'hff, 32'h0f, `POS_RESP_OKAY},
        '{`POS_ADDR_MINW, 32'h00, 32'h00, `POS_RESP_OKAY},
        '{`POS_ADDR_MINW, 32'h01, 32'h01, `POS_RESP_OKAY},
        '{`POS_ADDR_MINW, 32'h03, 32'h03, `POS_RESP_OKAY},
        '{`POS_ADDR_MINW, 32'h04, 32'h04, `POS_RESP_OKAY},
        '{`POS_ADDR_MINW, 32'h05, 32'h05, `POS_RESP_OKAY},
        '{`POS_ADDR_MINW, 32'h02, 32'h02, `POS_RESP_OKAY},
        '{`POS_ADDR_MASK, 32'h3f, 32'h3f, `POS_RESP_OKAY},
        '{16'h0000, 32'h55, 32'h00, `POS_RESP_SLVERR}
    };
    always #50 clk = ~clk;
    pos_top #(.TICK_CYCLES(20)) i_pos_top (
        .clk(clk), .srst(srst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .port_power_sense_pin_i(pin),
        .port_power_sense_pin_o(pin_o), .port_power_sense_pin_oe(pin_oe),
        .pullup_en(pullup_en), .irq(irq)
    );
    pos_switch_model i_pos_switch_model (
        .clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .oc_fault(oc_fault), .pin(pin)
    );
    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic timeout(input string n);
        errors++;
        $display("ERROR %s expected done seen timeout", n);
        summarize();
    endtask : timeout
    task automatic chk_word(input string n, input logic [31:0] e,
                            input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    task automatic chk_resp(input string n, input logic [1:0] e,
                            input logic [1:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask : chk_resp
    task automatic bus_write(input logic [15:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        int n;
        logic aw_hs, w_hs, b_hs;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            // settled values tell what the next rising edge takes
            @(negedge clk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = (s_axi_bvalid === 1'b1);
            r = s_axi_bresp;
            @(posedge clk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (b_hs) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 50) timeout("write");
    endtask : bus_write
    task automatic bus_read(input logic [15:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        logic ar_hs, r_hs;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = (s_axi_rvalid === 1'b1);
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (r_hs) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 50) timeout("read");
    endtask : bus_read
    task automatic rd_chk(input string n, input logic [15:0] a,
                          input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        bus_read(a, d, r);
        chk_word(n, e, d);
    endtask : rd_chk
    task automatic low_pulse(input int p, input int c);
        @(posedge clk);
        oc_fault[p] <= 1'b1;
        repeat (c) @(posedge clk);
        oc_fault[p] <= 1'b0;
    endtask : low_pulse
    task automatic wait_irq;
        int n;
        for (n = 0; n < 60; n++) begin
            @(negedge clk);
            if (irq === 1'b1) break;
        end
        if (n == 60) timeout("irq");
    endtask : wait_irq
    initial begin
        repeat (4) @(posedge clk);
        chk_word("pin_oe", 32'h3f, {26'h0, pin_oe});
        chk_word("pullup", 32'h00, {26'h0, pullup_en});
        chk_word("pin_o", 32'h00, {26'h0, pin_o});
        srst <= 1'b0;
        rd_chk("lockout", `POS_ADDR_LOCKOUT, 32'h0a);
        rd_chk("min width", `POS_ADDR_MINW, 32'h05);
        rd_chk("window", `POS_ADDR_WINDOW, 32'h14);
        rd_chk("status", `POS_ADDR_STATUS, 32'h00);
        $display("test reset done");
        for (int i = 0; i < 11; i++) begin
            bus_write(rows[i].a, rows[i].d, resp);
            chk_resp("write resp", rows[i].r, resp);
            bus_read(rows[i].a, data, resp);
            chk_word("read data", rows[i].e, data);
            chk_resp("read resp", rows[i].r, resp);
        end
        $display("test registers done");
        bus_write(`POS_ADDR_CTRL, 32'h3f, resp);
        low_pulse(0, 20);
        chk_word("pin_oe", 32'h00, {26'h0, pin_oe});
        chk_word("pullup", 32'h3f, {26'h0, pullup_en});
        repeat (100) @(posedge clk);
        rd_chk("status", `POS_ADDR_STATUS, 32'h00);
        $display("test lockout done");
        low_pulse(1, 15);
        repeat (100) @(posedge clk);
        rd_chk("status", `POS_ADDR_STATUS, 32'h00);
        low_pulse(1, 70);
        wait_irq();
        rd_chk("status", `POS_ADDR_STATUS, 32'h02);
        repeat (3) @(posedge clk);
        chk_word("irq", 32'h0, {31'h0, irq});
        $display("test single pulse done");
        low_pulse(2, 10);
        repeat (120) @(posedge clk);
        low_pulse(2, 10);
        repeat (100) @(posedge clk);
        rd_chk("status", `POS_ADDR_STATUS, 32'h00);
        low_pulse(2, 10);
        repeat (20) @(posedge clk);
        low_pulse(2, 10);
        wait_irq();
        rd_chk("status", `POS_ADDR_STATUS, 32'h04);
        $display("test double pulse done");
        bus_write(`POS_ADDR_MASK, 32'h00, resp);
        low_pulse(3, 70);
        repeat (20) @(posedge clk);
        chk_word("irq", 32'h0, {31'h0, irq});
        rd_chk("status", `POS_ADDR_STATUS, 32'h08);
        rd_chk("status", `POS_ADDR_STATUS, 32'h00);
        bus_write(`POS_ADDR_MASK, 32'h3f, resp);
        $display("test mask done");
        bus_write(`POS_ADDR_CTRL, 32'h13f, resp);
        repeat (100) @(posedge clk);
        low_pulse(0, 70);
        wait_irq();
        rd_chk("status", `POS_ADDR_STATUS, 32'h3f);
        bus_write(`POS_ADDR_CTRL, 32'h100, resp);
        repeat (3) @(posedge clk);
        chk_word("pin_oe", 32'h3f, {26'h0, pin_oe});
        chk_word("pullup", 32'h00, {26'h0, pullup_en});
        low_pulse(0, 70);
        repeat (20) @(posedge clk);
        rd_chk("status", `POS_ADDR_STATUS, 32'h00);
        $display("test ganged done");
        bus_write(`POS_ADDR_STATE, 32'h55, resp);
        chk_resp("state write", `POS_RESP_OKAY, resp);
        bus_write(`POS_ADDR_CTRL, 32'h3f, resp);
        repeat (10) @(posedge clk);
        rd_chk("ctrl", `POS_ADDR_CTRL, 32'h3f);
        rd_chk("state", `POS_ADDR_STATE, 32'h3f3f);
        $display("test state done");
        summarize();
    end
endmodule : port_overcurrent_sense_tb
